// ### shared/bmv_pkg.sv
// package: constants and carrier types for the memory and vga forwarding decoder
package bmv_pkg;
   // register offsets in configuration space
   localparam logic [7:0]  OFS_NP_BASE      = 8'h20;
   localparam logic [7:0]  OFS_NP_LIMIT     = 8'h22;
   localparam logic [7:0]  OFS_PF_BASE      = 8'h24;
   localparam logic [7:0]  OFS_PF_LIMIT     = 8'h26;
   localparam logic [7:0]  OFS_PF_BASE_UP   = 8'h28;
   localparam logic [7:0]  OFS_PF_LIMIT_UP  = 8'h2c;
   // window field layout and fixed low nibbles
   localparam int          WIN_HI           = 15;
   localparam int          WIN_LO           = 4;
   localparam logic [3:0]  NP_LOW_NIBBLE    = 4'h0;
   localparam logic [3:0]  PF_LOW_NIBBLE    = 4'h1;
   localparam logic [19:0] BASE_FILL        = 20'h00000;
   localparam logic [19:0] LIMIT_FILL       = 20'hfffff;
   // reset values of the 12-bit window fields (base 0, limit 000f_ffff)
   localparam logic [11:0] WIN_BASE_RST     = 12'h000;
   localparam logic [11:0] WIN_LIMIT_RST    = 12'h000;
   localparam logic [31:0] UPPER_RST        = 32'h0000_0000;
   // vga frame buffer bounds
   localparam logic [31:0] VGA_FB_LO        = 32'h000a_0000;
   localparam logic [31:0] VGA_FB_HI        = 32'h000b_ffff;
   // vga i/o ranges, 10-bit aliased port numbers
   localparam logic [9:0]  VGA_IO_A_LO      = 10'h3b0;
   localparam logic [9:0]  VGA_IO_A_HI      = 10'h3bb;
   localparam logic [9:0]  VGA_IO_B_LO      = 10'h3c0;
   localparam logic [9:0]  VGA_IO_B_HI      = 10'h3df;
   localparam logic [9:0]  PAL_PORT_0       = 10'h3c6;
   localparam logic [9:0]  PAL_PORT_1       = 10'h3c8;
   localparam logic [9:0]  PAL_PORT_2       = 10'h3c9;

   // bus command kinds seen by the decoder
   typedef enum logic [2:0] {
      BMV_CMD_MEM_RD, BMV_CMD_MEM_RD_LINE, BMV_CMD_MEM_RD_MULT,
      BMV_CMD_MEM_WR, BMV_CMD_IO_RD, BMV_CMD_IO_WR
   } bmv_cmd_t;

   // one transaction to decode
   typedef struct packed {
      logic        valid;
      logic        secondary;   // initiated on secondary bus
      bmv_cmd_t    cmd;
      logic        dac;         // dual address cycle
      logic [63:0] addr;
   } bmv_req_t;

   // decode result
   typedef struct packed {
      logic valid;
      logic fwd_down;
      logic fwd_up;
      logic claim;             // assert devsel on the initiating bus
      logic prefetch_ok;
      logic single_phase;
   } bmv_dec_t;

   // configuration write/read port
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  offset;
      logic [31:0] wdata;
      logic [3:0]  be;
   } bmv_cfg_t;

   // all state of the decoder except the byte enable register
   typedef struct packed {
      logic [11:0] np_base;
      logic [11:0] np_limit;
      logic [11:0] pf_base;
      logic [11:0] pf_limit;
      logic [31:0] pf_base_up;
      logic [31:0] pf_limit_up;
      logic [31:0] rdata;
      bmv_dec_t    dec;
   } bmv_state_t;
endpackage

// ### core/bmv_decoder.sv
// memory and vga forwarding decoder of a two-port bus bridge
`timescale 1ns/10ps
module bmv_decoder
   import bmv_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire bmv_cfg_t    cfg,
   output logic [31:0]      cfg_rdata,
   input  wire logic        mem_enable,
   input  wire logic        master_enable,
   input  wire logic        vga_enable,
   input  wire logic        vga_snoop,
   input  wire bmv_req_t    req,
   input  wire logic [3:0]  req_be,
   output bmv_dec_t         dec,
   output logic [3:0]       fwd_be
);
   bmv_state_t s_r;
   bmv_state_t s_nxt;

   // ************************************************************
   // address windows
   // ************************************************************
   logic [63:0] np_lo, np_hi, pf_lo, pf_hi, a64;
   logic        np_on, pf_on, np_hit, pf_hit;
   logic        is_mem, is_io, is_rd, fb_hit, io_ok, vga_io_hit, pal_hit;
   logic [9:0]  port;
   logic        vga_claim;

   // expand windows to full addresses
   always_comb begin
      np_lo = {32'h0, s_r.np_base, BASE_FILL};
      np_hi = {32'h0, s_r.np_limit, LIMIT_FILL};
      pf_lo = {s_r.pf_base_up, s_r.pf_base, BASE_FILL};
      pf_hi = {s_r.pf_limit_up, s_r.pf_limit, LIMIT_FILL};
      a64   = req.dac ? req.addr : {32'h0, req.addr[31:0]};
   end

   // enable checks and hit detection
   always_comb begin
      np_on  = (np_lo <= np_hi);
      pf_on  = (pf_lo <= pf_hi);
      np_hit = np_on && !req.dac && a64 >= np_lo && a64 <= np_hi;
      pf_hit = pf_on && a64 >= pf_lo && a64 <= pf_hi;
   end

   // command classes
   always_comb begin
      is_mem = (req.cmd == BMV_CMD_MEM_RD) || (req.cmd == BMV_CMD_MEM_RD_LINE) ||
               (req.cmd == BMV_CMD_MEM_RD_MULT) || (req.cmd == BMV_CMD_MEM_WR);
      is_io  = (req.cmd == BMV_CMD_IO_RD) || (req.cmd == BMV_CMD_IO_WR);
      is_rd  = is_mem && (req.cmd != BMV_CMD_MEM_WR);
   end

   // vga regions; bios region at c0000h lies outside and is not matched
   always_comb begin
      fb_hit     = !req.dac && req.addr[31:0] >= VGA_FB_LO &&
                   req.addr[31:0] <= VGA_FB_HI;
      port       = req.addr[9:0];                             // bits 15:10 ignored
      io_ok      = (req.addr[31:16] == 16'h0000);
      vga_io_hit = io_ok && ((port >= VGA_IO_A_LO && port <= VGA_IO_A_HI) ||
                             (port >= VGA_IO_B_LO && port <= VGA_IO_B_HI));
      pal_hit    = io_ok && req.cmd == BMV_CMD_IO_WR &&
                   (port == PAL_PORT_0 || port == PAL_PORT_1 ||
                    port == PAL_PORT_2);
      // vga mode wins over snoop when both set
      vga_claim  = vga_enable ? ((is_mem && fb_hit) || (is_io && vga_io_hit))
                              : (vga_snoop && pal_hit);
   end

   // ************************************************************
   // state update: registers and decode result
   // ************************************************************
   always_comb begin
      logic in_win;
      in_win = 1'b0;
      s_nxt = s_r;
      // configuration writes, byte enables honoured
      if (cfg.wr) begin
         unique case (cfg.offset)
            OFS_NP_BASE: begin
               if (cfg.be[0]) s_nxt.np_base[3:0]  = cfg.wdata[7:4];
               if (cfg.be[1]) s_nxt.np_base[11:4] = cfg.wdata[15:8];
               if (cfg.be[2]) s_nxt.np_limit[3:0]  = cfg.wdata[23:20];
               if (cfg.be[3]) s_nxt.np_limit[11:4] = cfg.wdata[31:24];
            end
            OFS_PF_BASE: begin
               if (cfg.be[0]) s_nxt.pf_base[3:0]  = cfg.wdata[7:4];
               if (cfg.be[1]) s_nxt.pf_base[11:4] = cfg.wdata[15:8];
               if (cfg.be[2]) s_nxt.pf_limit[3:0]  = cfg.wdata[23:20];
               if (cfg.be[3]) s_nxt.pf_limit[11:4] = cfg.wdata[31:24];
            end
            OFS_PF_BASE_UP: begin
               for (int i = 0; i < 4; i++)
                  if (cfg.be[i]) s_nxt.pf_base_up[i*8 +: 8] = cfg.wdata[i*8 +: 8];
            end
            OFS_PF_LIMIT_UP: begin
               for (int i = 0; i < 4; i++)
                  if (cfg.be[i]) s_nxt.pf_limit_up[i*8 +: 8] = cfg.wdata[i*8 +: 8];
            end
            default: ;
         endcase
      end
      // configuration reads, low nibbles fixed
      if (cfg.rd) begin
         unique case (cfg.offset)
            OFS_NP_BASE:     s_nxt.rdata = {s_r.np_limit, NP_LOW_NIBBLE,
                                            s_r.np_base, NP_LOW_NIBBLE};
            OFS_PF_BASE:     s_nxt.rdata = {s_r.pf_limit, PF_LOW_NIBBLE,
                                            s_r.pf_base, PF_LOW_NIBBLE};
            OFS_PF_BASE_UP:  s_nxt.rdata = s_r.pf_base_up;
            OFS_PF_LIMIT_UP: s_nxt.rdata = s_r.pf_limit_up;
            default:         s_nxt.rdata = 32'h0;
         endcase
      end
      // forwarding decision
      in_win = (is_mem && (np_hit || pf_hit)) || vga_claim;
      s_nxt.dec.valid    = req.valid && (is_mem || (is_io && vga_claim));
      s_nxt.dec.fwd_down = req.valid && !req.secondary && in_win &&
                           (is_mem ? mem_enable : 1'b1);
      s_nxt.dec.fwd_up   = req.valid && req.secondary && is_mem && !in_win &&
                           master_enable;
      s_nxt.dec.claim    = s_nxt.dec.fwd_down || s_nxt.dec.fwd_up;
      // prefetch: never in the vga frame buffer, else prefetch window and upstream any read, others line/multiple only
      s_nxt.dec.prefetch_ok = is_rd && (s_nxt.dec.fwd_down || s_nxt.dec.fwd_up) &&
                              !(vga_claim && is_mem) &&
                              (pf_hit || (req.secondary && !np_hit) ||
                               req.cmd != BMV_CMD_MEM_RD);
      s_nxt.dec.single_phase = is_rd && s_nxt.dec.claim && !s_nxt.dec.prefetch_ok;
   end

   // register the whole state
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r             <= '0;
         s_r.np_base     <= WIN_BASE_RST;
         s_r.np_limit    <= WIN_LIMIT_RST;
         s_r.pf_base     <= WIN_BASE_RST;
         s_r.pf_limit    <= WIN_LIMIT_RST;
         s_r.pf_base_up  <= UPPER_RST;
         s_r.pf_limit_up <= UPPER_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // byte enables passed through to target bus
   logic [3:0] be_r;
   always_ff @(posedge clk) begin
      if (rst) be_r <= 4'h0;
      else     be_r <= req_be;
   end

   assign dec       = s_r.dec;
   assign cfg_rdata = s_r.rdata;
   assign fwd_be    = be_r;

   // ************************************************************
   // checks
   // ************************************************************
   property p_np_down;
      @(posedge clk) disable iff (rst)
      (req.valid && !req.secondary && is_mem && np_hit && mem_enable) |=> dec.fwd_down;
   endproperty
   a_np_down: assert property (p_np_down) else $error("np hit not forwarded");
   property p_sec_ignore;
      @(posedge clk) disable iff (rst)
      (req.valid && req.secondary && is_mem && (np_hit || pf_hit)) |=> !dec.fwd_up;
   endproperty
   a_sec_ignore: assert property (p_sec_ignore) else $error("secondary hit went up");
   property p_up;
      @(posedge clk) disable iff (rst)
      (req.valid && req.secondary && is_mem && !np_hit && !pf_hit && !vga_claim
       && master_enable) |=> dec.fwd_up;
   endproperty
   a_up: assert property (p_up) else $error("miss not forwarded up");
   property p_memen;
      @(posedge clk) disable iff (rst) (is_mem && !mem_enable) |=> !dec.fwd_down;
   endproperty
   a_memen: assert property (p_memen) else $error("down without memory enable");
   property p_rd_single;
      @(posedge clk) disable iff (rst)
      (req.valid && !req.secondary && req.cmd == BMV_CMD_MEM_RD && np_hit && !pf_hit
       && mem_enable)
      |=> dec.single_phase;
   endproperty
   a_rd_single: assert property (p_rd_single) else $error("plain read prefetched");
   property p_np_off;
      @(posedge clk) disable iff (rst) (s_r.np_base > s_r.np_limit) |-> !np_hit;
   endproperty
   a_np_off: assert property (p_np_off) else $error("disabled window hit");
   property p_fb;
      @(posedge clk) disable iff (rst)
      (req.valid && !req.secondary && vga_enable && is_mem && !req.dac &&
       req.addr[31:16] == 16'h000a) |=> (dec.fwd_down == $past(mem_enable));
   endproperty
   a_fb: assert property (p_fb) else $error("frame buffer not forwarded");
   property p_pal;
      @(posedge clk) disable iff (rst)
      (req.valid && !req.secondary && vga_snoop && !vga_enable && pal_hit) |=> dec.claim;
   endproperty
   a_pal: assert property (p_pal) else $error("palette write not claimed");
   property p_rst_win;
      @(posedge clk) rst |=> (np_hi == 64'h0000_0000_000f_ffff && np_lo == 64'h0);
   endproperty
   a_rst_win: assert property (p_rst_win) else $error("window reset wrong");

   // ************************************************************
   // request-level checks built from named sequences
   // ************************************************************
   // a memory request from the primary side
   sequence s_prim_mem;
      req.valid && !req.secondary && is_mem;
   endsequence
   // a memory request from the secondary side
   sequence s_sec_mem;
      req.valid && req.secondary && is_mem;
   endsequence

   // prefetch window hit goes downstream
   property p_pf_down;
      @(posedge clk) disable iff (rst)
      (s_prim_mem ##0 (pf_hit && mem_enable)) |=> dec.fwd_down;
   endproperty
   a_pf_down: assert property (p_pf_down) else $error("prefetch hit not forwarded");

   // any read in the prefetch window may prefetch
   property p_pf_pref;
      @(posedge clk) disable iff (rst)
      (s_prim_mem ##0 (is_rd && pf_hit && !vga_claim && mem_enable)) |=> dec.prefetch_ok;
   endproperty
   a_pf_pref: assert property (p_pf_pref) else $error("prefetch read not allowed");

   // line and multiple reads prefetch in the other window
   property p_np_line;
      @(posedge clk) disable iff (rst)
      (s_prim_mem ##0 (is_rd && np_hit && !pf_hit && !vga_claim && mem_enable &&
       req.cmd != BMV_CMD_MEM_RD)) |=> dec.prefetch_ok;
   endproperty
   a_np_line: assert property (p_np_line) else $error("line read not prefetched");

   // frame buffer reads are single phase
   property p_fb_single;
      @(posedge clk) disable iff (rst)
      (s_prim_mem ##0 (is_rd && vga_enable && fb_hit && mem_enable))
      |=> (dec.single_phase && !dec.prefetch_ok);
   endproperty
   a_fb_single: assert property (p_fb_single) else $error("frame read prefetched");

   // byte enables follow one cycle later
   property p_be;
      @(posedge clk) disable iff (rst)
      req.valid |=> (fwd_be == $past(req_be));
   endproperty
   a_be: assert property (p_be) else $error("byte enables not passed");

   // no upstream forwarding without master enable
   property p_master;
      @(posedge clk) disable iff (rst)
      (s_sec_mem ##0 !master_enable) |=> !dec.fwd_up;
   endproperty
   a_master: assert property (p_master) else $error("up without master enable");

   // secondary accesses to vga regions are ignored
   property p_sec_vga;
      @(posedge clk) disable iff (rst)
      (req.valid && req.secondary && vga_claim) |=> (!dec.fwd_up && !dec.fwd_down);
   endproperty
   a_sec_vga: assert property (p_sec_vga) else $error("secondary vga forwarded");

   // vga i/o ports go downstream
   property p_vga_io;
      @(posedge clk) disable iff (rst)
      (req.valid && !req.secondary && is_io && vga_enable && vga_io_hit) |=> dec.fwd_down;
   endproperty
   a_vga_io: assert property (p_vga_io) else $error("vga port not forwarded");

   // i/o above the first 64KB never decoded as vga
   property p_io_hi;
      @(posedge clk) disable iff (rst)
      (req.valid && is_io && req.addr[31:16] != 16'h0000) |=> !dec.fwd_down;
   endproperty
   a_io_hi: assert property (p_io_hi) else $error("high i/o claimed");

   // bios region only forwarded through a window
   property p_bios;
      @(posedge clk) disable iff (rst)
      (s_prim_mem ##0 (!req.dac && req.addr[31:16] == 16'h000c && !np_hit && !pf_hit))
      |=> !dec.fwd_down;
   endproperty
   a_bios: assert property (p_bios) else $error("bios region decoded");

   // both vga bits act as vga mode
   property p_both;
      @(posedge clk) disable iff (rst)
      (req.valid && !req.secondary && vga_enable && vga_snoop && is_io && vga_io_hit) |=> dec.claim;
   endproperty
   a_both: assert property (p_both) else $error("vga port missed in both modes");

   // full 64-bit base above limit disables prefetch window
   property p_pf_off;
      @(posedge clk) disable iff (rst)
      ({s_r.pf_base_up, s_r.pf_base} > {s_r.pf_limit_up, s_r.pf_limit}) |-> !pf_hit;
   endproperty
   a_pf_off: assert property (p_pf_off) else $error("disabled prefetch window hit");

   // snoop mode leaves palette reads alone
   property p_pal_rd;
      @(posedge clk) disable iff (rst)
      (req.valid && vga_snoop && !vga_enable && req.cmd == BMV_CMD_IO_RD) |=> !dec.fwd_down;
   endproperty
   a_pal_rd: assert property (p_pal_rd) else $error("palette read forwarded");

   // dual address cycles never hit the 32-bit window
   property p_dac_np;
      @(posedge clk) disable iff (rst)
      (req.valid && req.dac) |-> !np_hit;
   endproperty
   a_dac_np: assert property (p_dac_np) else $error("dac hit 32-bit window");

   // low nibbles of the 20h dword read zero
   property p_np_nib;
      @(posedge clk) disable iff (rst)
      (cfg.rd && cfg.offset == OFS_NP_BASE)
      |=> (cfg_rdata[3:0] == NP_LOW_NIBBLE && cfg_rdata[19:16] == NP_LOW_NIBBLE);
   endproperty
   a_np_nib: assert property (p_np_nib) else $error("window nibble wrong");

   // low nibbles of the 24h dword read one
   property p_pf_nib;
      @(posedge clk) disable iff (rst)
      (cfg.rd && cfg.offset == OFS_PF_BASE)
      |=> (cfg_rdata[3:0] == PF_LOW_NIBBLE && cfg_rdata[19:16] == PF_LOW_NIBBLE);
   endproperty
   a_pf_nib: assert property (p_pf_nib) else $error("prefetch nibble wrong");

   // prefetch window resets to lowest 1MB
   property p_rst_pf;
      @(posedge clk) rst |=> (pf_hi == 64'h0000_0000_000f_ffff && pf_lo == 64'h0);
   endproperty
   a_rst_pf: assert property (p_rst_pf) else $error("prefetch reset wrong");

   // single cycle address misses a window with nonzero upper base
   property p_up_zero;
      @(posedge clk) disable iff (rst)
      (s_prim_mem ##0 (!req.dac && s_r.pf_base_up != 32'h0)) |-> !pf_hit;
   endproperty
   a_up_zero: assert property (p_up_zero) else $error("upper bits not zero");

   // the limit address itself lies inside the window
   property p_np_edge;
      @(posedge clk) disable iff (rst)
      (s_prim_mem ##0 (mem_enable && np_on && !req.dac && req.addr[31:0] == np_hi[31:0]))
      |=> dec.fwd_down;
   endproperty
   a_np_edge: assert property (p_np_edge) else $error("window limit missed");
endmodule

// ### tb/bmv_agent.sv
// bus agent model: presents memory and i/o requests to the decoder
`timescale 1ns/10ps
module bmv_agent
   import bmv_pkg::*;
(
   input  wire logic       clk,
   input  wire bmv_req_t   stim,
   input  wire logic [3:0] stim_be,
   output bmv_req_t        req,
   output logic [3:0]      req_be
);
   // ****************************************
   // request launch
   // ****************************************
   initial req = '0;
   initial req_be = 4'h0;
   // idle address phase shows a changing pattern, never the last address
   always @(posedge clk) begin : launch
      bmv_req_t nx;
      nx = stim;
      if (!stim.valid)
         nx.addr = ~req.addr;
      req <= nx;
      req_be <= stim.valid ? stim_be : ~req_be;
   end
endmodule

// ### tb/bmv_decoder_test.sv
// self-checking testbench for the memory and vga forwarding decoder
`timescale 1ns/10ps
module bmv_decoder_test
   import bmv_pkg::*;
;
   logic        clk = 0, rst = 1, mem_enable = 0, master_enable = 0;
   logic        vga_enable = 0, vga_snoop = 0, rd_d = 0;
   bmv_cfg_t    cfg = '0;
   bmv_req_t    stim = '0, req;
   bmv_dec_t    dec;
   logic [3:0]  stim_be = 0, req_be, fwd_be;
   logic [31:0] cfg_rdata, seed = 32'hfe84, bu = 0, lu = 0, dq[$], rq[$];
   logic [11:0] nb = 0, nl = 12'h000, pb = 0, pl = 12'h000;
   int          n_errors = 0, n_compared = 0, cyc = 0;
   logic [7:0]  ofs[5] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
   logic [63:0] wt[6] = '{'h0fff_ffff, 'h1000_0000, 'h1fff_ffff, 'h2000_0000,
                          'h2fff_ffff, 'h3000_0000};
   logic [63:0] vt[10] = '{'h3b0, 'h3bb, 'h3bc, 'h3c6, 'h3c7, 'h3c9, 'h3df, 'h3e0,
                           'h7c0, 'h103c0};
   logic [63:0] ft[4] = '{'h9ffff, 'ha0000, 'hbffff, 'hc0000};
   wire  [31:0] got = {23'h0, dec.fwd_down, dec.fwd_up, dec.claim, dec.prefetch_ok,
                       dec.single_phase, fwd_be};

   bmv_agent bmv_agent_i (.clk(clk), .stim(stim), .stim_be(stim_be), .req(req),
      .req_be(req_be));
   bmv_decoder bmv_decoder_i (.clk(clk), .rst(rst), .cfg(cfg), .cfg_rdata(cfg_rdata),
      .mem_enable(mem_enable), .master_enable(master_enable), .vga_enable(vga_enable),
      .vga_snoop(vga_snoop), .req(req), .req_be(req_be), .dec(dec), .fwd_be(fwd_be));

   always #25 clk = ~clk;

   // ****************************************
   // reference model and helpers
   // ****************************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // expected {down, up, claim, prefetch, single} for one request
   function automatic logic [4:0] model(bmv_req_t r);
      logic [63:0] a;
      logic        rd, mem, z, np, pf, fb, vio, pal, dn, up, po;
      a = r.dac ? r.addr : {32'h0, r.addr[31:0]};
      rd = r.cmd inside {BMV_CMD_MEM_RD, BMV_CMD_MEM_RD_LINE, BMV_CMD_MEM_RD_MULT};
      mem = rd || r.cmd == BMV_CMD_MEM_WR;
      z = !mem && a[31:16] == 16'h0;
      np = mem && !r.dac && a >= {nb, BASE_FILL} && a <= {nl, LIMIT_FILL};
      pf = mem && a >= {bu, pb, BASE_FILL} && a <= {lu, pl, LIMIT_FILL};
      fb = mem && vga_enable && a >= VGA_FB_LO && a <= VGA_FB_HI;
      vio = vga_enable && z && (a[9:0] inside {[VGA_IO_A_LO:VGA_IO_A_HI],
            [VGA_IO_B_LO:VGA_IO_B_HI]});
      pal = vga_snoop && z && r.cmd == BMV_CMD_IO_WR &&
            a[9:0] inside {PAL_PORT_0, PAL_PORT_1, PAL_PORT_2};
      dn = !r.secondary && (mem ? mem_enable && (np || pf || fb) : vio || pal);
      up = r.secondary && mem && master_enable && !(np || pf || fb);
      po = rd && (dn || up) && (fb ? 1'b0 : pf ? 1'b1 : np ? r.cmd != BMV_CMD_MEM_RD : up);
      return {dn, up, dn || up, po, rd && (dn || up) && !po};
   endfunction

   function automatic logic [31:0] rdx(logic [7:0] o);
      case (o)
         OFS_NP_BASE:     return {nl, NP_LOW_NIBBLE, nb, NP_LOW_NIBBLE};
         OFS_PF_BASE:     return {pl, PF_LOW_NIBBLE, pb, PF_LOW_NIBBLE};
         OFS_PF_BASE_UP:  return bu;
         OFS_PF_LIMIT_UP: return lu;
         default:         return 32'h0;
      endcase
   endfunction

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // configuration write or read, one dword with all lanes
   task automatic cop(input logic w, input logic [7:0] o, input logic [31:0] d);
      @(negedge clk);
      cfg = '{wr: w, rd: !w, offset: o, wdata: d, be: 4'hf};
      if (!w)
         rq.push_back(rdx(o));
      @(negedge clk);
      cfg.wr = 0;
      cfg.rd = 0;
      if (w)
         case (o)
            OFS_NP_BASE:     {nl, nb} = {d[31:20], d[15:4]};
            OFS_PF_BASE:     {pl, pb} = {d[31:20], d[15:4]};
            OFS_PF_BASE_UP:  bu = d;
            OFS_PF_LIMIT_UP: lu = d;
            default: ;
         endcase
   endtask

   task automatic rqt(input logic s, input bmv_cmd_t c, input logic x, input logic [63:0] a);
      logic [31:0] r;
      logic [4:0]  e;
      r = xs();
      @(negedge clk);
      stim = '{valid: 1'b1, secondary: s, cmd: c, dac: x, addr: a};
      stim_be = r[3:0];
      e = model(stim);
      // unclaimed i/o gives no decode result
      if (c inside {BMV_CMD_MEM_RD, BMV_CMD_MEM_RD_LINE, BMV_CMD_MEM_RD_MULT,
                    BMV_CMD_MEM_WR} || e[4])
         dq.push_back({23'h0, e, stim_be});
   endtask

   // enables change only with the buses idle
   task automatic ena(input logic m, input logic ms);
      @(negedge clk);
      stim.valid = 0;
      repeat (3) @(negedge clk);
      mem_enable = m;
      master_enable = ms;
   endtask

   task automatic done(input string t);
      ena(mem_enable, master_enable);
      $display("test %s done", t);
   endtask

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ****************************************
   // result watcher, timeout and main sequence
   // ****************************************
   always @(posedge clk) rd_d <= cfg.rd;

   always @(negedge clk) begin
      if (rd_d)
         check("cfg_rdata", cfg_rdata, rq.size() ? rq.pop_front() : 'x);
      if (dec.valid === 1'b1)
         check("dec", got, dq.size() ? dq.pop_front() : 'x);
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         final_report();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 0;
      foreach (ofs[i]) cop(0, ofs[i], 0);
      ena(1, 1);
      rqt(0, BMV_CMD_MEM_WR, 0, 'hfffff);
      rqt(0, BMV_CMD_MEM_WR, 0, 'h100000);
      rqt(1, BMV_CMD_MEM_WR, 0, 'h100000);
      rqt(1, BMV_CMD_MEM_RD_LINE, 0, 'h50);
      done("reset");
      ena(0, 0);
      foreach (ofs[i]) cop(1, ofs[i], '1);
      foreach (ofs[i]) cop(0, ofs[i], 0);
      cop(1, 8'h20, 32'h1ff0_1000);
      cop(1, 8'h24, 32'h2ff0_2000);
      cop(1, 8'h28, 0);
      cop(1, 8'h2c, 0);
      ena(1, 1);
      for (int c = 0; c < 4; c++)
         for (int s = 0; s < 2; s++)
            foreach (wt[i]) rqt(s[0], bmv_cmd_t'(c), 0, wt[i]);
      done("windows");
      ena(0, 0);
      cop(1, 8'h28, 1);
      cop(1, 8'h2c, 1);
      ena(1, 1);
      foreach (wt[i]) rqt(0, BMV_CMD_MEM_RD, 1, wt[i] | 64'h1_0000_0000);
      rqt(0, BMV_CMD_MEM_WR, 0, 'h2000_0000);
      rqt(0, BMV_CMD_MEM_WR, 1, 'h1000_0000);
      ena(0, 0);
      cop(1, 8'h2c, 2);
      cop(1, 8'h24, 32'h0ff0_2000);
      ena(1, 1);
      rqt(0, BMV_CMD_MEM_RD, 1, 'h1_5000_0000);
      ena(0, 0);
      cop(1, 8'h2c, 1);
      cop(1, 8'h20, 32'h0ff0_1000);
      ena(1, 1);
      rqt(0, BMV_CMD_MEM_RD, 1, 'h1_5000_0000);
      rqt(0, BMV_CMD_MEM_WR, 0, 'h1000_0000);
      rqt(1, BMV_CMD_MEM_WR, 0, 'h1000_0000);
      done("dac and disable");
      for (int m = 1; m < 4; m++) begin
         ena(0, 0);
         {vga_snoop, vga_enable} = 2'(m);
         ena(1, 1);
         foreach (vt[i]) rqt(0, BMV_CMD_IO_RD, 0, vt[i]);
         foreach (vt[i]) rqt(0, BMV_CMD_IO_WR, 0, vt[i]);
         foreach (ft[i]) rqt(0, BMV_CMD_MEM_RD, 0, ft[i]);
         foreach (ft[i]) rqt(1, BMV_CMD_MEM_RD, 0, ft[i]);
      end
      done("vga");
      ena(0, 0);
      cop(1, 8'h28, 0);
      cop(1, 8'h2c, 0);
      cop(1, 8'h24, 32'h2ff0_2000);
      cop(1, 8'h20, 32'h1ff0_1000);
      for (int k = 0; k < 4; k++) begin
         ena(k[0], k[1]);
         repeat (12) begin
            seed = xs();
            rqt(seed[31], bmv_cmd_t'(seed[5:4]), 0, {34'h0, seed[29:0]});
         end
      end
      done("random");
      check("pending", 32'(dq.size() + rq.size()), 0);
      final_report();
   end
endmodule
